// ===== tb/test_vip_vectored_irq_prioritizer.sv
// self-checking bench: register port stimulus, stream observed
// assumes 8 channels, 4 stored level bits, chain input enabled
module test_vip_vectored_irq_prioritizer;
  timeunit 1ns;
  timeprecision 1ns;
  import vip_pkg::*;
  localparam int unsigned NCH = 8; // 8 channels take 2 arbitration cycles
  logic            refClk, rst, csrRead, csrWrite, chainInValid;
  logic [NCH-1:0]  irqIn;
  logic [5:0]      csrAddress;
  logic [31:0]     csrWriteData, csrReadData, rnd;
  vip_vec_t        chainInData, outData, lastWord;
  logic            outValid, rdSeen, wdChk;
  logic [31:0]     rdQ[$];     // expected read words
  vip_vec_t        wdQ[$];     // expected stream words
  int              nMismatch, totalChecks;

  vip_vectored_irq_prioritizer #(.NUM_CH(NCH), .LEVEL_W(4),
    .CHAIN_EN(1'b1)) u_dut (.ref_clk(refClk), .rst(rst), .irqIn(irqIn),
    .csrAddress(csrAddress), .csrRead(csrRead), .csrWrite(csrWrite),
    .csrWriteData(csrWriteData), .csrReadData(csrReadData),
    .chainInValid(chainInValid), .chainInData(chainInData),
    .outValid(outValid), .outData(outData));
  vip_stream_sink u_sink (.ref_clk(refClk), .rst(rst),
    .outValid(outValid), .outData(outData), .lastWord(lastWord));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic vip_vec_t mk(logic [31:0] h, logic [5:0] rs,
                                  logic nm, logic [5:0] lv);
    return {h, rs, nm, lv};
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge refClk);
  endtask
  // full-word write, strobe for one edge then one idle edge
  task automatic csrWr(logic [5:0] a, logic [31:0] d);
    csrAddress <= a;
    csrWriteData <= d;
    csrWrite <= 1'b1;
    tick(1);
    csrWrite <= 1'b0;
    tick(1);
  endtask
  task automatic csrRd(logic [5:0] a, logic [31:0] e);
    rdQ.push_back(e);
    csrAddress <= a;
    csrRead <= 1'b1;
    tick(1);
    csrRead <= 1'b0;
    tick(1);
  endtask
  task automatic expWord(vip_vec_t w);
    wdQ.push_back(w);
    wdChk <= 1'b1;
    tick(1);
    wdChk <= 1'b0;
    tick(1);
  endtask
  task automatic cmpRd(logic [31:0] e, logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("[ERR] %0t read %h want %h", $time, g, e);
    end
  endtask
  task automatic cmpWord(vip_vec_t e, vip_vec_t g);
    totalChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("[ERR] %0t stream %h want %h", $time, g, e);
    end
  endtask
  task automatic results();
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    refClk = 1'b0;
    forever #5 refClk = ~refClk;
  end
  // read answer lands one edge after the taking edge
  always @(posedge refClk) begin
    if (rdSeen) cmpRd(rdQ.pop_front(), csrReadData);
    if (wdChk) cmpWord(wdQ.pop_front(), lastWord);
    rdSeen <= csrRead;
  end
  initial begin
    tick(2000);
    nMismatch++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; csrRead = 1'b0; csrWrite = 1'b0; chainInValid = 1'b0;
    irqIn = '0; csrAddress = '0; csrWriteData = '0; chainInData = '0;
    rdSeen = 1'b0; wdChk = 1'b0; nMismatch = 0; totalChecks = 0;
    rnd = $urandom(32'h50A2);
    tick(4);
    rst <= 1'b0;
    csrRd(OFS_ENABLE, 32'h0);
    csrRd(OFS_CFG_FIRST, 32'h0);
    expWord('0);
    csrWr(OFS_VBASE, 32'h0000_1003);
    csrRd(OFS_VBASE, 32'h0000_1000);
    csrWr(OFS_CTRL, 32'h0000_0010);
    csrRd(OFS_CTRL, 32'h0000_0010);
    csrWr(6'h01, 32'h0000_0140);           // level 0, never wins
    csrWr(6'h03, 32'hFFFF_E2D2);           // level bit 4 not stored
    csrWr(6'h05, 32'h0000_0082);
    csrWr(6'h06, 32'h0000_0187);
    csrRd(6'h03, 32'h0000_02C2);
    csrWr(OFS_EN_SET, 32'h0000_00FF);
    csrRd(OFS_EN_SET, 32'h0);
    csrWr(OFS_EN_CLR, 32'h0000_0001);
    csrRd(OFS_EN_CLR, 32'h0);
    csrRd(OFS_ENABLE, 32'h0000_00FE);
    irqIn <= 8'h2B;
    tick(6);
    expWord(mk(32'h1030, 6'h05, 1'b1, 6'h02));
    csrRd(OFS_PENDING, 32'h0000_002A);
    csrWr(OFS_EN_CLR, 32'h0000_0008);
    tick(4);
    expWord(mk(32'h1050, 6'h01, 1'b0, 6'h02));
    csrWr(OFS_SW_SET, 32'h0000_0040);
    tick(4);
    expWord(mk(32'h1060, 6'h03, 1'b0, 6'h07));
    csrRd(OFS_PENDING, 32'h0000_0062);
    rnd = $urandom;
    csrWr(6'h14, rnd);
    csrRd(6'h14, 32'h0);
    csrRd(6'h3F, 32'h0);
    rnd = $urandom;
    chainInData <= mk(rnd, 6'h2A, 1'b1, 6'h19);
    chainInValid <= 1'b1;
    tick(4);
    expWord(mk(rnd, 6'h2A, 1'b1, 6'h09));
    // chain still winning: status, handler and raw lines seen live
    csrRd(OFS_STATUS, 32'h0000_0049);
    csrRd(OFS_VADDR, rnd);
    csrRd(OFS_RAW, 32'h0000_002B);
    // direct trigger write keeps only implemented channels
    csrWr(OFS_SWTRIG, 32'h0000_0140);
    csrRd(OFS_SWTRIG, 32'h0000_0040);
    chainInValid <= 1'b0;
    irqIn <= '0;
    csrWr(OFS_SW_CLR, 32'hFFFF_FFFF);
    tick(6);
    expWord('0);
    // mid-run reset must clear the programmed state again
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    csrRd(OFS_ENABLE, 32'h0);
    csrRd(6'h03, 32'h0);
    csrRd(OFS_VBASE, 32'h0);
    tick(4);
    results();
  end
endmodule

// ===== tb/vip_irq_properties.sv
// timing checks on the prioritizer ports
// assumes one clock and an active-high asynchronous reset
module vip_irq_properties #(
  parameter int unsigned NUM_CH   = 32,  // implemented channels
  parameter int unsigned LEVEL_W  = 6,   // stored level bits
  parameter bit          CHAIN_EN = 1'b0 // chain input in use
) (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic [NUM_CH-1:0]          irqIn,
  input wire logic [vip_pkg::ADDR_W-1:0] csrAddress,
  input wire logic                       csrRead,
  input wire logic                       csrWrite,
  input wire logic [vip_pkg::DATA_W-1:0] csrWriteData,
  input wire logic [vip_pkg::DATA_W-1:0] csrReadData,
  input wire logic                       chainInValid,
  input wire vip_pkg::vip_vec_t          chainInData,
  input wire logic                       outValid,
  input wire vip_pkg::vip_vec_t          outData
);
  timeunit 1ns;
  timeprecision 1ns;
  import vip_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_valid_always: assert property (outValid)
    else $error("stream valid dropped");
  a_idle_zero: assert property (outData.requestLevel == '0 |->
    outData == '0) else $error("idle word not zero");
  a_read_holds: assert property (!csrRead |=> $stable(csrReadData))
    else $error("read data moved without a read");
  a_setclr_zero: assert property (csrRead && (csrAddress ==
    OFS_EN_SET || csrAddress == OFS_EN_CLR) |=> csrReadData == '0)
    else $error("set or clear word read nonzero");
  a_absent_cfg: assert property (csrRead && csrAddress < 6'h20 &&
    csrAddress >= NUM_CH |=> csrReadData == '0)
    else $error("absent channel config nonzero");
  a_cfg_reserved: assert property (csrRead && csrAddress < 6'h20
    |=> csrReadData[31:13] == '0) else $error("reserved bits set");
  a_reset_clears: assert property ($fell(rst) |-> outData == '0 &&
    csrReadData == '0) else $error("state left after reset");
  a_stream_settles: assert property (($stable(irqIn) && !csrWrite &&
    $stable(chainInValid) && $stable(chainInData)) [*6] |=>
    $stable(outData)) else $error("stream moved on quiet inputs");
  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_winner: cover property (outData.requestLevel != '0);
  c_clear: cover property (csrWrite && csrAddress == OFS_EN_CLR);
  c_chain: cover property (chainInValid && outData == chainInData);
endmodule

bind vip_vectored_irq_prioritizer vip_irq_properties #(
  .NUM_CH(NUM_CH), .LEVEL_W(LEVEL_W), .CHAIN_EN(CHAIN_EN)
) u_props (
  .ref_clk(ref_clk), .rst(rst), .irqIn(irqIn), .csrAddress(csrAddress),
  .csrRead(csrRead), .csrWrite(csrWrite), .csrWriteData(csrWriteData),
  .csrReadData(csrReadData), .chainInValid(chainInValid),
  .chainInData(chainInData), .outValid(outValid), .outData(outData)
);

// ===== tb/vip_stream_sink.sv
// far-side model: processor port taking the stream every cycle
// assumes the prioritizer clock and its active-high reset
module vip_stream_sink (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              outValid,
  input  wire vip_pkg::vip_vec_t outData,
  output vip_pkg::vip_vec_t      lastWord
);
  timeunit 1ns;
  timeprecision 1ns;
  import vip_pkg::*;
  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // never stalls: takes each valid word, no ready back to sender
  // lowest-latency sources belong on the unit nearest this port
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lastWord <= '0;
    end else if (outValid) begin
      lastWord <= outData;
    end
  end
endmodule

// ===== verilog/vip_pkg.sv
// shared constants and carriers of the vectored interrupt prioritizer
// assumes a word-addressed register port and one 100 MHz clock
package vip_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 6;   // word index of a register
  localparam int DATA_W    = 32;  // register word
  localparam int MAX_CH    = 32;  // most channels one unit holds
  localparam int IDX_W     = 5;   // channel index
  localparam int FIELD_W   = 6;   // level and register-set fields
  localparam int HANDLER_W = 32;  // handler address
  localparam int BPV_W     = 16;  // bytes-per-vector field

  // ----------------------------------------------------------------
  // register word indices
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CFG_FIRST = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG_LAST  = 6'h1F;
  localparam logic [ADDR_W-1:0] OFS_ENABLE    = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_EN_SET    = 6'h21;
  localparam logic [ADDR_W-1:0] OFS_EN_CLR    = 6'h22;
  localparam logic [ADDR_W-1:0] OFS_PENDING   = 6'h23;
  localparam logic [ADDR_W-1:0] OFS_RAW       = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_SWTRIG    = 6'h25;
  localparam logic [ADDR_W-1:0] OFS_SW_SET    = 6'h26;
  localparam logic [ADDR_W-1:0] OFS_SW_CLR    = 6'h27;
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 6'h29;
  localparam logic [ADDR_W-1:0] OFS_VBASE     = 6'h2A;
  localparam logic [ADDR_W-1:0] OFS_VADDR     = 6'h2B;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_ZERO   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ALIGN_MASK = 32'hFFFF_FFFC;

  // per-channel configuration word
  typedef struct packed {
    logic [18:0]        reserved;
    logic [FIELD_W-1:0] requestRegisterSet;
    logic               requestNonmaskable;
    logic [FIELD_W-1:0] requestLevel;
  } vip_cfg_t;

  // 45-bit streaming word
  typedef struct packed {
    logic [HANDLER_W-1:0] handlerAddress;
    logic [FIELD_W-1:0]   requestRegisterSet;
    logic                 requestNonmaskable;
    logic [FIELD_W-1:0]   requestLevel;
  } vip_vec_t;

  // arbitration result on its way to vector generation
  typedef struct packed {
    logic             fromChain;
    logic [IDX_W-1:0] idx;
    vip_vec_t         info;
  } vip_cand_t;

endpackage

// ===== verilog/vip_vectored_irq_prioritizer.sv
// vectored interrupt prioritizer: enables, software triggers,
// level arbitration, handler address and a chained stream output
// assumes a word-addressed register master of 32 bits, and a chain
// input driven by logic on the same clock
//
// Functional notes
// R01: channel requested by hardware line or software bit
// R02: channel count is a build parameter, max 32
// R03: numerically largest level wins arbitration
// R04: level tie goes to lowest channel index
// R05: level zero means channel never wins
// R06: level field width is a build parameter
// R07: handler is index times spacing plus base
// R08: winner with handler address sent on stream
// R09: chain input arbitrated, forwarded unmodified if winning
// R10: wider incoming chain level truncated to own width
// R11: two cycles conditioning, one cycle vector generation
// R12: arbitration takes one, two or three cycles
// R13: operator puts fastest interrupts nearest processor
// R14: full 32-bit registers, no byte enables
// R15: registers reached through memory-mapped slave port
// R16: absent channel config reads zero, ignores writes
// R17: enable bit n steers channel n
// R18: disabled channel is left out of arbitration
// R19: enable-set writes ones set, reads zero
// R20: enable-clear writes ones clear, reads zero
// R21: pending register shows one bit per channel
// R22: stream always valid, no backpressure, 45 bits
// R23: config word: level, non-maskable bit, register set
// R24: pending holds while enabled and requested
// R25: software bit ORed with line before enable
// R26: nothing pending gives zero level and address
// R27: lines sampled on clock, reset clears configuration
module vip_vectored_irq_prioritizer #(
  parameter int unsigned NUM_CH   = 32,   // implemented channels
  parameter int unsigned LEVEL_W  = 6,    // stored level bits
  parameter bit          CHAIN_EN = 1'b0  // chain input in use
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic [NUM_CH-1:0]            irqIn,
  input  wire logic [vip_pkg::ADDR_W-1:0]   csrAddress,
  input  wire logic                         csrRead,
  input  wire logic                         csrWrite,
  input  wire logic [vip_pkg::DATA_W-1:0]   csrWriteData,
  output      logic [vip_pkg::DATA_W-1:0]   csrReadData,
  input  wire logic                         chainInValid,
  input  wire vip_pkg::vip_vec_t            chainInData,
  output      logic                         outValid,
  output      vip_pkg::vip_vec_t            outData
);
  import vip_pkg::*;

  // ----------------------------------------------------------------
  // derived constants
  // ----------------------------------------------------------------
  // arbitration depth follows channel count
  localparam int ARB_STAGES = (NUM_CH <= 4)  ? 1 :
                              (NUM_CH <= 16) ? 2 : 3; // R12
  // implemented channels
  localparam logic [MAX_CH-1:0] CH_MASK =
    MAX_CH'((64'h1 << NUM_CH) - 64'h1); // R02
  // stored level bits; wider bits drop away
  localparam logic [FIELD_W-1:0] LEVEL_MASK =
    FIELD_W'((1 << LEVEL_W) - 1); // R06 R10

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  vip_cfg_t          cfgMem [NUM_CH];   // per-channel config
  vip_cfg_t          next_cfgMem [NUM_CH];
  logic [MAX_CH-1:0] channelEnable;     // enable bits
  logic [MAX_CH-1:0] next_channelEnable;
  logic [MAX_CH-1:0] swTrigger;         // software triggers
  logic [MAX_CH-1:0] next_swTrigger;
  logic [BPV_W-1:0]  bytesPerVector;    // vector spacing
  logic [BPV_W-1:0]  next_bytesPerVector;
  logic [DATA_W-1:0] vectorBase;        // table base
  logic [DATA_W-1:0] next_vectorBase;
  logic [NUM_CH-1:0] irqMeta;           // first sync stage
  logic [NUM_CH-1:0] irqSync;           // second sync stage
  vip_cand_t         arbPipe [ARB_STAGES]; // arbitration delay
  vip_cand_t         next_arbPipe [ARB_STAGES];
  vip_vec_t          next_outData;
  logic              outFromChain;      // chain won last vector
  logic              next_outFromChain;
  logic [DATA_W-1:0] next_csrReadData;

  // ----------------------------------------------------------------
  // request conditioning
  // ----------------------------------------------------------------
  logic [MAX_CH-1:0] rawStatus;  // unmasked hardware lines
  logic [MAX_CH-1:0] pending;    // enabled requests
  vip_cand_t         cand;       // arbitration winner

  // raw lines widened to the register word
  always_comb begin
    rawStatus = '0;
    rawStatus[NUM_CH-1:0] = irqSync;
  end

  // line or software bit, then enable; absent channels drop
  assign pending = (rawStatus | swTrigger) // R01 R25
                 & channelEnable & CH_MASK; // R18 R24

  // two-flop sampling of the asynchronous lines
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqMeta <= '0;
      irqSync <= '0;
    end else begin
      irqMeta <= irqIn; // R27
      irqSync <= irqMeta; // R11
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // next values of all software-written state
  always_comb begin
    next_cfgMem         = cfgMem;
    next_channelEnable  = channelEnable;
    next_swTrigger      = swTrigger;
    next_bytesPerVector = bytesPerVector;
    next_vectorBase     = vectorBase;
    if (csrWrite) begin // R14 R15
      // configuration words of implemented channels only
      for (int i = 0; i < NUM_CH; i++) begin
        if (csrAddress == ADDR_W'(i)) begin // R16
          next_cfgMem[i] = vip_cfg_t'(csrWriteData); // R23
          next_cfgMem[i].reserved = '0;
          next_cfgMem[i].requestLevel =
            next_cfgMem[i].requestLevel & LEVEL_MASK; // R06
        end
      end
      case (csrAddress)
        OFS_ENABLE: begin // R17
          next_channelEnable = csrWriteData & CH_MASK;
        end
        OFS_EN_SET: begin // R19
          next_channelEnable =
            channelEnable | (csrWriteData & CH_MASK);
        end
        OFS_EN_CLR: begin // R20
          next_channelEnable = channelEnable & ~csrWriteData;
        end
        OFS_SWTRIG: begin // R01
          next_swTrigger = csrWriteData & CH_MASK;
        end
        OFS_SW_SET: begin
          next_swTrigger = swTrigger | (csrWriteData & CH_MASK);
        end
        OFS_SW_CLR: begin
          next_swTrigger = swTrigger & ~csrWriteData;
        end
        OFS_CTRL: begin
          next_bytesPerVector = csrWriteData[BPV_W-1:0];
        end
        OFS_VBASE: begin
          // base is word aligned
          next_vectorBase = csrWriteData & ALIGN_MASK;
        end
        default: begin
          // other words hold no writable state
        end
      endcase
    end
  end

  // registers of the software-written state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin // R27
      for (int i = 0; i < NUM_CH; i++) begin
        cfgMem[i] <= '0;
      end
      channelEnable  <= '0;
      swTrigger      <= '0;
      bytesPerVector <= '0;
      vectorBase     <= '0;
    end else begin
      cfgMem         <= next_cfgMem;
      channelEnable  <= next_channelEnable;
      swTrigger      <= next_swTrigger;
      bytesPerVector <= next_bytesPerVector;
      vectorBase     <= next_vectorBase;
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic [FIELD_W-1:0] chainLevel; // chain level at own width

  assign chainLevel = chainInData.requestLevel & LEVEL_MASK; // R10

  // strict compare keeps the lowest index on ties
  always_comb begin
    cand = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (pending[i] &&
          cfgMem[i].requestLevel > cand.info.requestLevel) begin
        // R03 R04 R05
        cand.idx = IDX_W'(i);
        cand.info.requestLevel = cfgMem[i].requestLevel;
        cand.info.requestNonmaskable =
          cfgMem[i].requestNonmaskable;
        cand.info.requestRegisterSet =
          cfgMem[i].requestRegisterSet;
      end
    end
    // chain beats local only with a strictly higher level
    if (CHAIN_EN && chainInValid &&
        chainLevel > cand.info.requestLevel) begin // R09
      cand.fromChain = 1'b1;
      cand.idx = '0;
      cand.info = chainInData;
      cand.info.requestLevel = chainLevel;
    end
  end

  // shift the winner through the arbitration delay
  always_comb begin
    next_arbPipe[0] = cand;
    for (int s = 1; s < ARB_STAGES; s++) begin
      next_arbPipe[s] = arbPipe[s-1]; // R12
    end
  end

  // arbitration delay registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < ARB_STAGES; s++) begin
        arbPipe[s] <= '0;
      end
    end else begin
      arbPipe <= next_arbPipe;
    end
  end

  // ----------------------------------------------------------------
  // vector generation
  // ----------------------------------------------------------------
  // handler address of the winner, or chain word with its level cut to own width
  always_comb begin
    next_outData = arbPipe[ARB_STAGES-1].info;
    next_outFromChain = arbPipe[ARB_STAGES-1].fromChain;
    if (!arbPipe[ARB_STAGES-1].fromChain) begin
      next_outData.handlerAddress = HANDLER_W'( // R07
        HANDLER_W'(arbPipe[ARB_STAGES-1].idx) *
        HANDLER_W'(bytesPerVector)) + vectorBase;
    end
    if (arbPipe[ARB_STAGES-1].info.requestLevel == '0) begin
      // nothing pending: all fields zero
      next_outData = '0; // R26
      next_outFromChain = 1'b0;
    end
  end

  // output register, one cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      outData      <= '0;
      outFromChain <= 1'b0;
    end else begin
      outData      <= next_outData; // R08 R11
      outFromChain <= next_outFromChain;
    end
  end

  // stream never stalls
  assign outValid = 1'b1; // R22

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // read word chosen by index, unmapped words read zero
  always_comb begin
    next_csrReadData = csrReadData;
    if (csrRead) begin
      next_csrReadData = REG_ZERO;
      if (csrAddress <= OFS_CFG_LAST) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (csrAddress == OFS_CFG_FIRST + ADDR_W'(i)) begin
            next_csrReadData = DATA_W'(cfgMem[i]); // R16
          end
        end
      end
      case (csrAddress)
        OFS_ENABLE: begin
          next_csrReadData = channelEnable;
        end
        OFS_PENDING: begin
          next_csrReadData = pending; // R21
        end
        OFS_RAW: begin
          next_csrReadData = rawStatus;
        end
        OFS_SWTRIG: begin
          next_csrReadData = swTrigger;
        end
        OFS_CTRL: begin
          next_csrReadData = DATA_W'(bytesPerVector);
        end
        OFS_STATUS: begin
          // current level and whether chain supplied it
          next_csrReadData = DATA_W'({outFromChain,
                                      outData.requestLevel});
        end
        OFS_VBASE: begin
          next_csrReadData = vectorBase;
        end
        OFS_VADDR: begin
          next_csrReadData = outData.handlerAddress;
        end
        default: begin
          // set and clear words read zero here
        end
      endcase
    end
  end

  // read data register, held until the next read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csrReadData <= REG_ZERO;
    end else begin
      csrReadData <= next_csrReadData; // R19 R20
    end
  end

endmodule
